// file: src/vsf_dev.sv
// Purpose: Video stream framing monitor with pass-through FIFO
// Assumes: Both sides on aclk; control bus answers only while enabled
// Notes:   Sticky error flags, mask, level interrupt
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`include "vsf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module vsf_dev
  import vsf_pkg::*;
#(
  parameter logic [31:0] VERSION = `VSF_VERSION_VAL  // Arbitrary value
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  vsf_if.dev        bus,
  output logic      irq,
  output logic      init_done
);
  localparam int DEPTH = `VSF_FIFO_DEPTH;
  localparam int INITC = `VSF_INIT_CYCLES;

  logic             rst_n;
  logic [4:0]       init_cnt_r;
  logic             init_done_r;
  logic [25:0]      mem_r [DEPTH];
  logic [1:0]       wr_ptr_r;
  logic [1:0]       rd_ptr_r;
  logic [2:0]       fill_r;
  logic             push;
  logic             pop;
  logic             full;
  logic             s_hs;
  logic             eol;
  logic             sof;
  vsf_cnt_t         px_cnt_r;
  vsf_cnt_t         ln_cnt_r;
  logic             frame_seen_r;
  vsf_cnt_t         width;
  vsf_cnt_t         height;
  logic [3:0]       err_ev;
  logic [3:0]       err_r;
  logic [3:0]       err_clr;
  logic [3:0]       mask_r;
  logic [31:0]      size_r;
  logic [31:0]      wmask;
  logic             wr_hs;
  logic             rd_hs;
  logic             wr_err;
  logic             wr_mask;
  logic             wr_size;
  logic             wr_ok;
  logic             rd_ok;
  logic [31:0]      rd_data;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             rvalid_r;
  logic [31:0]      rdata_r;
  logic [1:0]       rresp_r;

  // Either reset holds the device
  assign rst_n = aresetn & bus.ctl_rst_n;

  // Initialization period
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      init_cnt_r  <= 5'h00;
      init_done_r <= 1'b0;
    end else if (!init_done_r) begin
      init_cnt_r  <= init_cnt_r + 5'h01;
      init_done_r <= (init_cnt_r == 5'(INITC - 1));
    end
  end
  assign init_done = init_done_r;

  // Pass-through FIFO
  assign full  = (fill_r == 3'(DEPTH));
  assign bus.s_axis_video_tready = init_done_r & ~full;
  assign s_hs  = bus.s_axis_video_tvalid & bus.s_axis_video_tready;
  assign push  = s_hs;
  assign pop   = bus.m_axis_video_tvalid & bus.m_axis_video_tready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= {bus.s_axis_video_tuser, bus.s_axis_video_tlast,
                          bus.s_axis_video_tdata};
    end
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
      fill_r   <= 3'h0;
    end else begin
      wr_ptr_r <= wr_ptr_r + {1'b0, push};
      rd_ptr_r <= rd_ptr_r + {1'b0, pop};
      fill_r   <= fill_r + {2'h0, push} - {2'h0, pop};
    end
  end

  assign bus.m_axis_video_tvalid = (fill_r != 3'h0);
  assign bus.m_axis_video_tdata  = mem_r[rd_ptr_r][23:0];
  assign bus.m_axis_video_tlast  = mem_r[rd_ptr_r][24];
  assign bus.m_axis_video_tuser  = mem_r[rd_ptr_r][25];

  // Framing checks
  assign eol    = s_hs & bus.s_axis_video_tlast;
  assign sof    = s_hs & bus.s_axis_video_tuser;
  assign width  = size_r[15:0];
  assign height = size_r[31:16];
  assign err_ev[`VSF_ERR_SHORT]    = eol & ((px_cnt_r + 16'h1) < width);
  assign err_ev[`VSF_ERR_LONG]     = s_hs & (px_cnt_r == width);
  assign err_ev[`VSF_ERR_SOF_ERLY] = sof & frame_seen_r & (ln_cnt_r < height);
  assign err_ev[`VSF_ERR_SOF_LATE] = eol & ~sof & (ln_cnt_r == height);

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      px_cnt_r     <= 16'h0;
      ln_cnt_r     <= 16'h0;
      frame_seen_r <= 1'b0;
    end else if (s_hs) begin
      px_cnt_r <= eol ? 16'h0 : px_cnt_r + 16'h1;
      if (sof) begin
        frame_seen_r <= 1'b1;
        ln_cnt_r     <= {15'h0, eol};
      end else if (eol) begin
        ln_cnt_r <= ln_cnt_r + 16'h1;
      end
    end
  end

  // Control bus decode
  assign wr_hs   = bus.awvalid & bus.awready;
  assign rd_hs   = bus.arvalid & bus.arready;
  // No handshake while held in reset, so no answer is lost
  assign bus.awready = rst_n & bus.ctl_en & bus.awvalid & bus.wvalid & ~bvalid_r;
  assign bus.wready  = bus.awready;
  assign bus.arready = rst_n & bus.ctl_en & ~rvalid_r;
  assign wr_err  = wr_hs & (bus.awaddr == `VSF_OFF_ERROR);
  assign wr_mask = wr_hs & (bus.awaddr == `VSF_OFF_MASK);
  assign wr_size = wr_hs & (bus.awaddr == `VSF_OFF_SIZE);
  assign wr_ok   = (bus.awaddr == `VSF_OFF_STATUS) | (bus.awaddr == `VSF_OFF_ERROR) |
                   (bus.awaddr == `VSF_OFF_MASK) | (bus.awaddr == `VSF_OFF_SIZE) |
                   (bus.awaddr == `VSF_OFF_VERSION);
  assign rd_ok   = (bus.araddr == `VSF_OFF_STATUS) | (bus.araddr == `VSF_OFF_ERROR) |
                   (bus.araddr == `VSF_OFF_MASK) | (bus.araddr == `VSF_OFF_SIZE) |
                   (bus.araddr == `VSF_OFF_VERSION);
  assign err_clr = (wr_err & bus.wstrb[0]) ? bus.wdata[3:0] : 4'h0;
  assign rd_data =
    (bus.araddr == `VSF_OFF_STATUS)  ? {30'h0, full, init_done_r} :
    (bus.araddr == `VSF_OFF_ERROR)   ? {28'h0, err_r} :
    (bus.araddr == `VSF_OFF_MASK)    ? {28'h0, mask_r} :
    (bus.araddr == `VSF_OFF_SIZE)    ? size_r :
    (bus.araddr == `VSF_OFF_VERSION) ? VERSION : 32'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{bus.wstrb[gi]}};
    end
  endgenerate

  // Sticky errors, set wins over clear
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      err_r <= 4'h0;
    end else begin
      err_r <= (err_r & ~err_clr) | err_ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      mask_r <= 4'h0;
      size_r <= `VSF_SIZE_RST;
    end else begin
      if (wr_mask && bus.wstrb[0]) begin
        mask_r <= bus.wdata[3:0];
      end
      if (wr_size) begin
        size_r <= (size_r & ~wmask) | (bus.wdata & wmask);
      end
    end
  end

  assign irq = |(err_r & mask_r);

  // Write response
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `VSF_RESP_OKAY;
    end else if (wr_hs) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? `VSF_RESP_OKAY : `VSF_RESP_SLVERR;
    end else if (bus.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= `VSF_RESP_OKAY;
    end else if (rd_hs) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_data;
      rresp_r  <= rd_ok ? `VSF_RESP_OKAY : `VSF_RESP_SLVERR;
    end else if (bus.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign bus.bvalid = bvalid_r;
  assign bus.bresp  = bresp_r;
  assign bus.rvalid = rvalid_r;
  assign bus.rdata  = rdata_r;
  assign bus.rresp  = rresp_r;

endmodule : vsf_dev
`default_nettype wire

// file: src/vsf_map.svh
// Purpose: Register offsets, fields, reset values and counts
// Assumes: 32-bit AXI4-Lite data, word-aligned registers
// Notes:   Shared by both ends
`ifndef VSF_MAP_SVH
`define VSF_MAP_SVH
`define VSF_OFF_STATUS   12'h000
`define VSF_OFF_ERROR    12'h004
`define VSF_OFF_MASK     12'h008
`define VSF_OFF_SIZE     12'h00c
`define VSF_OFF_VERSION  12'h010
`define VSF_ERR_SHORT    0
`define VSF_ERR_LONG     1
`define VSF_ERR_SOF_ERLY 2
`define VSF_ERR_SOF_LATE 3
`define VSF_SIZE_RST     32'h0438_0780
`define VSF_VERSION_VAL  32'h0001_0000
`define VSF_INIT_NS      160
`define VSF_CLK_NS       10
`define VSF_INIT_CYCLES  (`VSF_INIT_NS / `VSF_CLK_NS)
`define VSF_FIFO_DEPTH   4
`define VSF_RESP_OKAY    2'h0
`define VSF_RESP_SLVERR  2'h2
`endif

// file: src/vsf_pkg.sv
// Purpose: Types shared by both ends
// Assumes: 24-bit pixels
// Notes:   Constants live in vsf_map.svh
package vsf_pkg;
  typedef logic [23:0] vsf_pix_t;
  typedef logic [15:0] vsf_cnt_t;
  typedef enum logic [1:0] {VSF_IDLE, VSF_WR, VSF_RD} vsf_mst_e;
endpackage : vsf_pkg

// file: src/vsf_if.sv
// Purpose: Video streams, control bus, control reset and enable between ends
// Assumes: One clock aclk for both ends
// Notes:   dev is the monitor, oth is source, sink and host
`timescale 1ns/1ps
`default_nettype none
interface vsf_if;
  import vsf_pkg::*;
  logic       s_axis_video_tvalid;
  logic       s_axis_video_tready;
  vsf_pix_t   s_axis_video_tdata;
  logic       s_axis_video_tlast;
  logic       s_axis_video_tuser;
  logic       m_axis_video_tvalid;
  logic       m_axis_video_tready;
  vsf_pix_t   m_axis_video_tdata;
  logic       m_axis_video_tlast;
  logic       m_axis_video_tuser;
  logic       awvalid, awready, wvalid, wready, bvalid, bready;
  logic       arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic       ctl_rst_n;
  logic       ctl_en;
  modport dev (
    input  s_axis_video_tvalid, s_axis_video_tdata, s_axis_video_tlast,
    input  s_axis_video_tuser, m_axis_video_tready,
    output s_axis_video_tready, m_axis_video_tvalid, m_axis_video_tdata,
    output m_axis_video_tlast, m_axis_video_tuser,
    input  awvalid, awaddr, wvalid, wdata, wstrb, bready, arvalid, araddr, rready,
    output awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp,
    input  ctl_rst_n, ctl_en
  );
  modport oth (
    output s_axis_video_tvalid, s_axis_video_tdata, s_axis_video_tlast,
    output s_axis_video_tuser, m_axis_video_tready,
    input  s_axis_video_tready, m_axis_video_tvalid, m_axis_video_tdata,
    input  m_axis_video_tlast, m_axis_video_tuser,
    output awvalid, awaddr, wvalid, wdata, wstrb, bready, arvalid, araddr, rready,
    input  awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp,
    output ctl_rst_n, ctl_en
  );
endinterface : vsf_if
`default_nettype wire

// file: src/vsf_oth.sv
// Purpose: Source, sink and control master facing the monitor
// Assumes: One command at a time; single clock aclk
// Notes:   Drives control reset and enable from user inputs
`include "vsf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module vsf_oth
  import vsf_pkg::*;
(
  input  wire logic  aclk,
  input  wire logic  aresetn,
  vsf_if.oth         bus,
  input  wire logic  ctl_rst_n_in,
  input  wire logic  ctl_en_in,
  input  wire logic  src_valid,
  output logic       src_ready,
  input  wire vsf_pix_t src_data,
  input  wire logic  src_eol,
  input  wire logic  src_sof,
  output logic       snk_valid,
  input  wire logic  snk_ready,
  output vsf_pix_t   snk_data,
  output logic       snk_eol,
  output logic       snk_sof,
  input  wire logic  cmd_valid,
  output logic       cmd_ready,
  input  wire logic  cmd_write,
  input  wire logic [11:0] cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  output logic       rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic [1:0] rsp_resp
);
  vsf_mst_e    st_r;
  logic        sv_r, sl_r, su_r, kv_r, kl_r, ku_r;
  vsf_pix_t    sd_r, kd_r;
  logic        aw_r, w_r, ar_r, rv_r;
  logic [11:0] addr_r;
  logic [31:0] wd_r, rd_r;
  logic [1:0]  rs_r;
  logic        take;
  logic        s_hs;
  logic        m_hs;

  assign bus.ctl_rst_n = ctl_rst_n_in;
  assign bus.ctl_en    = ctl_en_in;

  // Source stage, holds until taken
  assign s_hs      = sv_r & bus.s_axis_video_tready;
  assign src_ready = ~sv_r | bus.s_axis_video_tready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sv_r <= 1'b0;
      sd_r <= 24'h0;
      sl_r <= 1'b0;
      su_r <= 1'b0;
    end else if (src_ready) begin
      sv_r <= src_valid;
      sd_r <= src_data;
      sl_r <= src_eol;
      su_r <= src_sof;
    end
  end
  assign bus.s_axis_video_tvalid = sv_r;
  assign bus.s_axis_video_tdata  = sd_r;
  assign bus.s_axis_video_tlast  = sl_r;
  assign bus.s_axis_video_tuser  = su_r;

  // Sink stage, back-pressure passes through
  assign bus.m_axis_video_tready = ~kv_r | snk_ready;
  assign m_hs = bus.m_axis_video_tvalid & bus.m_axis_video_tready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kv_r <= 1'b0;
      kd_r <= 24'h0;
      kl_r <= 1'b0;
      ku_r <= 1'b0;
    end else if (bus.m_axis_video_tready) begin
      kv_r <= bus.m_axis_video_tvalid;
      kd_r <= bus.m_axis_video_tdata;
      kl_r <= bus.m_axis_video_tlast;
      ku_r <= bus.m_axis_video_tuser;
    end
  end
  assign snk_valid = kv_r;
  assign snk_data  = kd_r;
  assign snk_eol   = kl_r;
  assign snk_sof   = ku_r;

  // Control master
  assign cmd_ready = (st_r == VSF_IDLE);
  assign take      = cmd_valid & cmd_ready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= VSF_IDLE;
      aw_r   <= 1'b0;
      w_r    <= 1'b0;
      ar_r   <= 1'b0;
      addr_r <= 12'h0;
      wd_r   <= 32'h0;
      rv_r   <= 1'b0;
      rd_r   <= 32'h0;
      rs_r   <= 2'h0;
    end else begin
      rv_r <= 1'b0;
      unique case (st_r)
        VSF_IDLE: begin
          if (take) begin
            addr_r <= cmd_addr;
            wd_r   <= cmd_wdata;
            aw_r   <= cmd_write;
            w_r    <= cmd_write;
            ar_r   <= ~cmd_write;
            st_r   <= cmd_write ? VSF_WR : VSF_RD;
          end
        end
        VSF_WR: begin
          if (bus.awready) aw_r <= 1'b0;
          if (bus.wready) w_r <= 1'b0;
          if (bus.bvalid) begin
            rv_r <= 1'b1;
            rd_r <= 32'h0;
            rs_r <= bus.bresp;
            st_r <= VSF_IDLE;
          end
        end
        VSF_RD: begin
          if (bus.arready) ar_r <= 1'b0;
          if (bus.rvalid) begin
            rv_r <= 1'b1;
            rd_r <= bus.rdata;
            rs_r <= bus.rresp;
            st_r <= VSF_IDLE;
          end
        end
      endcase
    end
  end
  assign bus.awvalid = aw_r;
  assign bus.wvalid  = w_r;
  assign bus.arvalid = ar_r;
  assign bus.awaddr  = addr_r;
  assign bus.araddr  = addr_r;
  assign bus.wdata   = wd_r;
  assign bus.wstrb   = 4'hf;
  assign bus.bready  = (st_r == VSF_WR);
  assign bus.rready  = (st_r == VSF_RD);
  assign rsp_valid   = rv_r;
  assign rsp_rdata   = rd_r;
  assign rsp_resp    = rs_r;

endmodule : vsf_oth
`default_nettype wire

// file: tb/vsf_chk_sva.sv
// Purpose: Link checks between monitor and partner
// Assumes: One clock; either low reset holds the device
// Notes:   Occupancy and init counters in helper logic
`include "vsf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module vsf_chk_sva
  import vsf_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ctl_rst_n,
  input wire logic        ctl_en,
  input wire logic        s_axis_video_tvalid,
  input wire logic        s_axis_video_tready,
  input wire logic        m_axis_video_tvalid,
  input wire logic        m_axis_video_tready,
  input wire vsf_pix_t    m_axis_video_tdata,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [11:0] araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata
);
  logic       rst_w;
  logic       in_w;
  logic       out_w;
  logic [4:0] up_r;
  logic [2:0] occ_r;
  assign rst_w = !aresetn || !ctl_rst_n;
  assign in_w  = s_axis_video_tvalid && s_axis_video_tready;
  assign out_w = m_axis_video_tvalid && m_axis_video_tready;
  // Cycles since release and beats held inside
  always_ff @(posedge aclk) begin
    if (rst_w) begin
      up_r  <= 5'h00;
      occ_r <= 3'h0;
    end else begin
      up_r  <= (up_r == 5'h1f) ? up_r : up_r + 5'h01;
      occ_r <= occ_r + {2'h0, in_w} - {2'h0, out_w};
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (rst_w);
  a_init_low: assert property (up_r <= 5'h0f |-> !s_axis_video_tready)
    else $error("input ready high during init");
  a_room_ready: assert property (up_r > 5'h0f && occ_r < 3'h4 |-> s_axis_video_tready)
    else $error("input ready low with room");
  a_full_stall: assert property (occ_r == 3'h4 |-> !s_axis_video_tready)
    else $error("input ready high when full");
  a_no_phantom: assert property (occ_r == 3'h0 |-> !m_axis_video_tvalid)
    else $error("output beat with nothing taken");
  a_out_hold: assert property (m_axis_video_tvalid && !m_axis_video_tready |=>
    m_axis_video_tvalid && $stable(m_axis_video_tdata))
    else $error("output beat changed while stalled");
  a_bus_gated: assert property (!ctl_en |-> !awready && !arready)
    else $error("control bus ready while disabled");
  a_b_answer: assert property (awvalid && awready |=> bvalid)
    else $error("write answer missing");
  a_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer missing");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_ver_value: assert property (arvalid && arready && araddr == `VSF_OFF_VERSION
    |=> rdata == `VSF_VERSION_VAL)
    else $error("version value wrong");
  c_full: cover property (occ_r == 3'h4);
  c_write: cover property (awvalid && awready ##1 bvalid && bready);
  c_gated: cover property (!ctl_en && arvalid);
endmodule : vsf_chk_sva
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the framing monitor and its partner
// Assumes: Both ends on aclk; partner end faces the monitor
// Notes:   Rows hold frame start, line length and expected flags
`include "vsf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import vsf_pkg::*;
;
  // {sof, pixels, expected flags}
  localparam logic [7:0] ROWS [8] = '{8'hc0, 8'h40, 8'hb1, 8'h52, 8'hc0, 8'hc4, 8'h40, 8'h48};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ctl_rst_n_in = 1'b1;
  logic        ctl_en_in = 1'b1;
  logic        src_valid = 1'b0;
  logic        src_ready;
  vsf_pix_t    src_data = 24'h000000;
  logic        src_eol = 1'b0;
  logic        src_sof = 1'b0;
  logic        snk_valid;
  logic        snk_ready = 1'b1;
  vsf_pix_t    snk_data;
  logic        snk_eol;
  logic        snk_sof;
  logic        cmd_valid = 1'b0;
  logic        cmd_ready;
  logic        cmd_write = 1'b0;
  logic [11:0] cmd_addr = 12'h000;
  logic [31:0] cmd_wdata = 32'h0;
  logic        rsp_valid;
  logic [31:0] rsp_rdata;
  logic [1:0]  rsp_resp;
  logic        irq;
  logic        init_done;
  logic [31:0] rd;
  logic [1:0]  rs;
  logic [25:0] exp_q[$];
  int          pix, n_rsp, n_mismatch, comparisons;
  vsf_if v ();
  vsf_dev i_vsf_dev (.aclk(aclk), .aresetn(aresetn), .bus(v), .irq(irq), .init_done(init_done));
  vsf_oth i_vsf_oth (.aclk(aclk), .aresetn(aresetn), .bus(v), .ctl_rst_n_in(ctl_rst_n_in),
    .ctl_en_in(ctl_en_in), .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
    .src_eol(src_eol), .src_sof(src_sof), .snk_valid(snk_valid), .snk_ready(snk_ready),
    .snk_data(snk_data), .snk_eol(snk_eol), .snk_sof(snk_sof), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_resp(rsp_resp));
  vsf_chk_sva i_vsf_chk_sva (.aclk(aclk), .aresetn(aresetn), .ctl_rst_n(v.ctl_rst_n),
    .ctl_en(v.ctl_en), .s_axis_video_tvalid(v.s_axis_video_tvalid),
    .s_axis_video_tready(v.s_axis_video_tready), .m_axis_video_tvalid(v.m_axis_video_tvalid),
    .m_axis_video_tready(v.m_axis_video_tready), .m_axis_video_tdata(v.m_axis_video_tdata),
    .awvalid(v.awvalid), .awready(v.awready), .bvalid(v.bvalid), .bready(v.bready),
    .arvalid(v.arvalid), .arready(v.arready),
    .araddr(v.araddr), .rvalid(v.rvalid), .rready(v.rready), .rdata(v.rdata));
  always #5 aclk = ~aclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // Returns at the rising edge where the signal is seen high
  task automatic wait_hi(ref logic s);
    bit ok;
    do begin
      @(negedge aclk);
      ok = (s === 1'b1);
      @(posedge aclk);
    end while (!ok);
  endtask : wait_hi
  task automatic op(input logic wr, input logic [11:0] a, input logic [31:0] d);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr  <= a;
    cmd_wdata <= d;
    wait_hi(cmd_ready);
    cmd_valid <= 1'b0;
    wait_hi(rsp_valid);
  endtask : op
  task automatic line(input int n, input logic sof);
    for (int i = 0; i < n; i++) begin
      src_valid <= 1'b1;
      src_data  <= pix[23:0];
      src_eol   <= (i == n - 1);
      src_sof   <= sof && (i == 0);
      exp_q.push_back({sof && (i == 0), i == n - 1, pix[23:0]});
      pix++;
      wait_hi(src_ready);
    end
    src_valid <= 1'b0;
  endtask : line
  // Answer capture and sink beat comparison
  always @(negedge aclk) begin
    if (rsp_valid === 1'b1) begin
      rd = rsp_rdata;
      rs = rsp_resp;
      n_rsp++;
    end
    if (snk_valid === 1'b1 && snk_ready === 1'b1) begin
      chk({6'h00, snk_sof, snk_eol, snk_data}, {6'h00, exp_q.pop_front()});
    end
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    int n;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (init_done !== 1'b1);
    chk(n, `VSF_INIT_CYCLES + 1);
    @(posedge aclk);
    op(1'b1, `VSF_OFF_SIZE, 32'h0002_0004);
    op(1'b1, `VSF_OFF_MASK, 32'h0000_000f);
    foreach (ROWS[i]) begin
      line(int'(ROWS[i][6:4]), ROWS[i][7]);
      repeat (4) @(posedge aclk);
      op(1'b0, `VSF_OFF_ERROR, 32'h0);
      chk(rd, {28'h0, ROWS[i][3:0]});
      chk({31'h0, irq}, {31'h0, ROWS[i][3:0] != 4'h0});
      op(1'b1, `VSF_OFF_ERROR, 32'h0000_000f);
      chk({31'h0, irq}, 32'h0);
    end
    // Masked flag stays set until written with a one
    op(1'b1, `VSF_OFF_MASK, 32'h0);
    line(3, 1'b1);
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    op(1'b0, `VSF_OFF_ERROR, 32'h0);
    op(1'b0, `VSF_OFF_ERROR, 32'h0);
    chk(rd, 32'h1);
    op(1'b1, `VSF_OFF_MASK, 32'h1);
    op(1'b1, `VSF_OFF_ERROR, 32'h0);
    chk({31'h0, irq}, 32'h1);
    op(1'b1, `VSF_OFF_ERROR, 32'h1);
    chk({31'h0, irq}, 32'h0);
    op(1'b0, `VSF_OFF_VERSION, 32'h0);
    chk(rd, `VSF_VERSION_VAL);
    chk({30'h0, rs}, {30'h0, `VSF_RESP_OKAY});
    op(1'b0, `VSF_OFF_STATUS, 32'h0);
    chk(rd, 32'h1);
    op(1'b0, 12'h020, 32'h0);
    chk({30'h0, rs}, {30'h0, `VSF_RESP_SLVERR});
    op(1'b1, 12'h020, 32'h0);
    chk({30'h0, rs}, {30'h0, `VSF_RESP_SLVERR});
    // No answer while the control enable is low
    ctl_en_in <= 1'b0;
    n = n_rsp;
    fork
      op(1'b0, `VSF_OFF_VERSION, 32'h0);
      begin
        repeat (10) @(posedge aclk);
        chk(n_rsp, n);
        ctl_en_in <= 1'b1;
      end
    join
    chk(rd, `VSF_VERSION_VAL);
    // Sink stall fills the buffer and stalls the source
    snk_ready <= 1'b0;
    fork
      line(8, 1'b1);
      begin
        repeat (30) @(posedge aclk);
        op(1'b0, `VSF_OFF_STATUS, 32'h0);
        chk(rd, 32'h3);
        chk({31'h0, v.s_axis_video_tready}, 32'h0);
        snk_ready <= 1'b1;
      end
    join
    repeat (20) @(posedge aclk);
    chk(exp_q.size(), 0);
    // Control reset alone restarts the device
    ctl_rst_n_in <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({31'h0, init_done}, 32'h0);
    ctl_rst_n_in <= 1'b1;
    wait_hi(init_done);
    op(1'b0, `VSF_OFF_ERROR, 32'h0);
    chk(rd, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
